/* File: rtl/pas_pkg.sv */
// Constants and types of the alarm supervisor
package pas_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYC = CLK_HZ / MS_PER_S;
  localparam int FAST_ON_MS = 20;
  localparam int FAST_OFF_S = 5;
  localparam int FAST_OFF_MS = FAST_OFF_S * MS_PER_S;
  localparam int RETRY_DAYS = 4;
  localparam int S_PER_DAY = 86400;
  localparam int RETRY_S = RETRY_DAYS * S_PER_DAY;
  // ------------------------------------------------------------
  // Scaling
  // ------------------------------------------------------------
  localparam int VLOSS_PCT = 20;
  localparam int PCT_FULL = 100;
  localparam int WEAR_UNIT = 1000;
  // ------------------------------------------------------------
  // Alarm indices
  // ------------------------------------------------------------
  localparam int N_STD_IN = 9;
  localparam int N_DLY = 15;
  localparam int N_ALL = 19;
  localparam int ALM_UV = 0;
  localparam int ALM_OV = 1;
  localparam int ALM_UC = 2;
  localparam int ALM_OC = 3;
  localparam int ALM_HL = 4;
  localparam int ALM_VD = 5;
  localparam int ALM_ID = 6;
  localparam int ALM_OVC = 7;
  localparam int ALM_UNC = 8;
  localparam int ALM_P = 9;
  localparam int ALM_CF = 10;
  localparam int ALM_T1 = 11;
  localparam int ALM_T2 = 12;
  localparam int ALM_NC = 13;
  localparam int ALM_RF = 14;
  localparam int ALM_VL = 15;
  localparam int ALM_EXT = 16;
  localparam int ALM_WEAR = 17;
  localparam int ALM_OE = 18;
  localparam logic [N_ALL-1:0] ACT_OK = ~((19'h00001 << ALM_OC)
    | (19'h00001 << ALM_OVC) | (19'h00001 << ALM_UNC)
    | (19'h00001 << ALM_CF) | (19'h00001 << ALM_NC)
    | (19'h00001 << ALM_RF) | (19'h00001 << ALM_WEAR));
  localparam logic [N_ALL-1:0] KEEP_FIXED = (19'h00001 << ALM_UC)
    | (19'h00001 << ALM_P);
  typedef enum logic {PAS_W_RD, PAS_W_CMP} pas_wst_t;
endpackage

/* File: rtl/pas_mem_if.sv */
// Port group between the supervisor and its counter memory
`timescale 1ns/1ps
interface pas_mem_if #(parameter int AW = 5, parameter int DW = 24);
  logic we;
  logic [AW-1:0] waddr;
  logic [AW-1:0] raddr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctl (output we, output waddr, output raddr, output wdata,
    input rdata);
  modport mem (input we, input waddr, input raddr, input wdata,
    output rdata);
endinterface

/* File: rtl/pas_cnt_mem.sv */
// Switching counter store, registered read
`timescale 1ns/1ps
module pas_cnt_mem #(
  parameter int DEPTH = 18,
  parameter int AW = 5,
  parameter int DW = 24
) (
  input wire logic clk,
  input wire logic rst,
  pas_mem_if.mem m
);
  logic [DEPTH-1:0][DW-1:0] mem_ff;
  logic [DW-1:0] rdata_ff;

  assign m.rdata = rdata_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_ff <= '0;
      rdata_ff <= '0;
    end else begin
      if (m.we && (int'(m.waddr) < DEPTH)) begin
        mem_ff[m.waddr] <= m.wdata;
      end
      rdata_ff <= (int'(m.raddr) < DEPTH) ? mem_ff[m.raddr] : '0;
    end
  end
endmodule

/* File: rtl/pas_supervisor.sv */
// Alarm supervision of the power factor controller
`timescale 1ns/1ps
module pas_supervisor import pas_pkg::*; #(
  parameter int NS = 18,
  parameter int W = 16,
  parameter int MS_CYCLES = MS_CYC,
  parameter int RETRY_SEC = RETRY_S,
  parameter bit HAS_EXT = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [N_STD_IN-1:0] std_cond,
  input wire logic [2:0][W-1:0] u_ln,
  input wire logic [W-1:0] u_nom,
  input wire logic signed [W-1:0] p_fh,
  input wire logic signed [W-1:0] p_lim,
  input wire logic p_signed,
  input wire logic p_above,
  input wire logic signed [W-1:0] dq_ctl,
  input wire logic [W-1:0] ctl_bw,
  input wire logic signed [W-1:0] internal_temperature,
  input wire logic signed [W-1:0] external_temperature,
  input wire logic [1:0] t_src_ext,
  input wire logic [1:0] t_above,
  input wire logic [1:0][W-1:0] t_lim,
  input wire logic ext_in,
  input wire logic ctl_running,
  input wire logic output_recognition,
  input wire logic aor_start,
  input wire logic auto_connection_detection,
  input wire logic ct_test,
  input wire logic [N_ALL-1:0] ind_en,
  input wire logic [N_ALL-1:0] act_en,
  input wire logic [N_DLY-1:0][10:0] dly_s,
  input wire logic [13:0] wear_lim_k,
  input wire logic [6:0] oe_pct,
  input wire logic [3:0] oe_dly,
  input wire logic [NS-1:0] sec_fixed,
  input wire logic [NS-1:0][2:0] sec_ph,
  input wire logic [NS-1:0] sec_edit,
  input wire logic [NS-1:0] sec_alarm_out,
  input wire logic [NS-1:0] sec_alarm_pol,
  input wire logic [NS-1:0] ctl_on,
  input wire logic [NS-1:0] cnt_clr,
  input wire logic sw_evt,
  input wire logic [$clog2(NS)-1:0] sw_idx,
  input wire logic [2:0][W-1:0] sw_q,
  input wire logic [2:0][W-1:0] sw_dq,
  output logic [N_ALL-1:0] alarm_active,
  output logic [NS-1:0] contact,
  output logic [NS-1:0] sec_faulty,
  output logic [NS-1:0] sec_disabled,
  output logic standby_req
);
  localparam int AW = $clog2(NS);
  localparam int CW = 24;
  localparam int RW = $clog2(RETRY_SEC + 1);
  localparam int MW = $clog2(MS_CYCLES + 1);

  typedef struct packed {
    logic [MW-1:0] ms_div;
    logic [9:0] s_div;
    logic [N_DLY-1:0] dly_act;
    logic [N_DLY-1:0][10:0] dly_cnt;
    logic [3:0] fast_act;
    logic [3:0][12:0] fast_cnt;
    logic [NS-1:0] force_off;
    logic [NS-1:0] disabled;
    logic [NS-1:0] faulty;
    logic [NS-1:0][3:0] oe_cnt;
    logic [NS-1:0] oe_hi;
    logic [NS-1:0] wear_pend;
    logic [NS-1:0] clr_pend;
    logic [NS-1:0] wear_flag;
    logic [AW-1:0] ptr;
    pas_wst_t wst;
    logic [RW-1:0] retry_cnt;
    logic retry_on;
    logic [N_ALL-1:0] alarm;
    logic [NS-1:0] contact;
    logic standby;
  } pas_state_t;

  pas_state_t st_ff;
  pas_state_t nxt_st;
  pas_mem_if #(.AW(AW), .DW(CW)) mif ();

  pas_cnt_mem #(.DEPTH(NS), .AW(AW), .DW(CW)) u_mem (
    .clk(clk),
    .rst(rst),
    .m(mif.mem)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic vloss(input logic [W-1:0] u,
                                 input logic [W-1:0] nom);
    return (32'(u) * PCT_FULL) < (32'(nom) * VLOSS_PCT);
  endfunction

  function automatic logic [1:0] oe_miss(input logic [W-1:0] q,
                                         input logic [W-1:0] dq,
                                         input logic [6:0] pct);
    logic [31:0] tol;
    tol = (32'(q) * 32'(pct)) / PCT_FULL;
    return {32'(dq) > 32'(q) + tol, 32'(dq) + tol < 32'(q)};
  endfunction

  function automatic logic [W-1:0] mag(input logic signed [W-1:0] v);
    return v[W-1] ? W'(-v) : W'(v);
  endfunction

  // ------------------------------------------------------------
  // Conditions
  // ------------------------------------------------------------
  logic signed [W-1:0] p_val;
  logic p_cond;
  logic cf_cond;
  logic [1:0] t_cond;
  logic [N_DLY-1:0] cond;
  logic [3:0] fcond;
  logic [N_ALL-1:0] act_ok;
  logic [N_ALL-1:0] act_alm;
  logic suppress;
  logic ms_tick;
  logic s_tick;

  assign p_val = p_signed ? p_fh : $signed(mag(p_fh));
  assign p_cond = p_above ? (p_val > p_lim) : (p_val < p_lim);
  assign cf_cond = mag(dq_ctl) > ctl_bw;

  always_comb begin
    for (int k = 0; k < 2; k++) begin
      logic signed [W-1:0] tv;
      tv = t_src_ext[k] ? external_temperature : internal_temperature;
      t_cond[k] = t_above[k] ? (tv > $signed(t_lim[k]))
                             : (tv < $signed(t_lim[k]));
    end
  end

  // Remote failure is tied inactive; not-controlling is control idle
  assign cond = {1'b0, !ctl_running, t_cond, cf_cond, p_cond,
                 std_cond};
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      fcond[p] = vloss(u_ln[p], u_nom);
    end
    fcond[3] = HAS_EXT && ext_in;
  end

  assign ms_tick = (st_ff.ms_div == '0);
  assign s_tick = ms_tick && (st_ff.s_div == '0);
  assign suppress = output_recognition || auto_connection_detection
                    || ct_test;
  assign act_ok = act_en & ACT_OK;
  always_comb begin
    act_alm = '0;
    act_alm[N_DLY-1:0] = st_ff.dly_act & act_ok[N_DLY-1:0];
    if (suppress) begin
      act_alm = act_alm & ~KEEP_FIXED;
    end
  end

  // ------------------------------------------------------------
  // Actuation masks
  // ------------------------------------------------------------
  logic full_act;
  logic part_act;
  logic [NS-1:0] slow_mask;
  logic [NS-1:0] fast_mask;
  logic [NS-1:0] step_pick;

  assign full_act = |(act_alm & ~KEEP_FIXED);
  assign part_act = |(act_alm & KEEP_FIXED);
  assign slow_mask = full_act ? '1 : (part_act ? ~sec_fixed : '0);
  always_comb begin
    fast_mask = '0;
    for (int p = 0; p < 3; p++) begin
      for (int s = 0; s < NS; s++) begin
        if (st_ff.fast_act[p] && act_ok[ALM_VL] && sec_ph[s][p]) begin
          fast_mask[s] = 1'b1;
        end
      end
    end
    if (st_ff.fast_act[3] && act_ok[ALM_EXT]) begin
      fast_mask = '1;
    end
  end
  // Lowest pending section first, one per second
  assign step_pick = s_tick ? ((slow_mask & ~st_ff.force_off)
                     & (~(slow_mask & ~st_ff.force_off) + 1'b1)) : '0;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  logic [NS-1:0] sw_mask;
  logic [1:0] miss;
  logic [CW-1:0] new_cnt;
  logic any_ind;

  assign sw_mask = sw_evt ? (NS'(1) << sw_idx) : '0;
  assign mif.raddr = st_ff.ptr;
  assign mif.waddr = st_ff.ptr;
  assign new_cnt = st_ff.clr_pend[st_ff.ptr] ? '0
                   : mif.rdata + CW'(st_ff.wear_pend[st_ff.ptr]);
  assign mif.wdata = new_cnt;
  assign mif.we = (st_ff.wst == PAS_W_CMP)
                  && (st_ff.clr_pend[st_ff.ptr] || st_ff.wear_pend[st_ff.ptr]);
  always_comb begin
    miss = '0;
    for (int p = 0; p < 3; p++) begin
      miss = miss | oe_miss(sw_q[p], sw_dq[p], oe_pct);
    end
  end
  assign any_ind = |(st_ff.alarm & (ind_en | act_ok));

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ms_div = ms_tick ? MW'(MS_CYCLES - 1) : st_ff.ms_div - 1'b1;
    if (ms_tick) begin
      nxt_st.s_div = (st_ff.s_div == '0) ? 10'(MS_PER_S - 1)
                                          : st_ff.s_div - 1'b1;
    end
    for (int i = 0; i < N_DLY; i++) begin
      if (cond[i] == st_ff.dly_act[i]) begin
        nxt_st.dly_cnt[i] = '0;
      end else if (s_tick) begin
        // A tick may fall just after the change, so count one extra
        if (st_ff.dly_cnt[i] >= dly_s[i] && st_ff.dly_cnt[i] != '0) begin
          nxt_st.dly_act[i] = cond[i];
          nxt_st.dly_cnt[i] = '0;
        end else begin
          nxt_st.dly_cnt[i] = st_ff.dly_cnt[i] + 1'b1;
        end
      end
    end
    if (ctl_running) begin
      nxt_st.dly_act[ALM_NC] = 1'b0;
    end
    for (int f = 0; f < 4; f++) begin
      if (fcond[f] == st_ff.fast_act[f]) begin
        nxt_st.fast_cnt[f] = '0;
      end else if (ms_tick) begin
        // Release waits one extra tick so the 5 s is never cut short
        if (st_ff.fast_act[f] ? (st_ff.fast_cnt[f] >= 13'(FAST_OFF_MS))
            : (st_ff.fast_cnt[f] + 1'b1 >= 13'(FAST_ON_MS))) begin
          nxt_st.fast_act[f] = fcond[f];
          nxt_st.fast_cnt[f] = '0;
        end else begin
          nxt_st.fast_cnt[f] = st_ff.fast_cnt[f] + 1'b1;
        end
      end
    end
    // Sections stay off only while some actuation still covers them
    nxt_st.force_off = (st_ff.force_off | fast_mask | step_pick)
                       & (slow_mask | fast_mask);
    nxt_st.standby = |(slow_mask | fast_mask);
    // Wear scan: one output per two cycles, far faster than switching
    nxt_st.wear_pend = st_ff.wear_pend | sw_mask;
    nxt_st.clr_pend = st_ff.clr_pend | cnt_clr;
    case (st_ff.wst)
      PAS_W_RD: begin
        nxt_st.wst = PAS_W_CMP;
      end
      PAS_W_CMP: begin
        nxt_st.wear_flag[st_ff.ptr] =
          new_cnt > CW'(32'(wear_lim_k) * WEAR_UNIT);
        nxt_st.wear_pend[st_ff.ptr] = sw_mask[st_ff.ptr];
        nxt_st.clr_pend[st_ff.ptr] = cnt_clr[st_ff.ptr];
        nxt_st.ptr = (int'(st_ff.ptr) == NS - 1) ? '0
                     : st_ff.ptr + 1'b1;
        nxt_st.wst = PAS_W_RD;
      end
      default: begin
        nxt_st.wst = PAS_W_RD;
      end
    endcase
    // Re-enable first so that a same-cycle fault still lands
    if (aor_start) begin
      nxt_st.disabled = '0;
      nxt_st.faulty = '0;
      nxt_st.oe_cnt = '0;
    end
    nxt_st.disabled = nxt_st.disabled & ~sec_edit;
    nxt_st.faulty = nxt_st.faulty & ~sec_edit;
    if (s_tick && !st_ff.retry_on) begin
      if (int'(st_ff.retry_cnt) >= RETRY_SEC - 1) begin
        nxt_st.retry_on = 1'b1;
        nxt_st.retry_cnt = '0;
      end else begin
        nxt_st.retry_cnt = st_ff.retry_cnt + 1'b1;
      end
    end
    if (sw_evt && (ind_en[ALM_OE] || act_en[ALM_OE])) begin
      if (st_ff.disabled[sw_idx]) begin
        if (st_ff.retry_on) begin
          nxt_st.retry_on = 1'b0;
          if (miss == 2'b00) begin
            nxt_st.disabled[sw_idx] = 1'b0;
            nxt_st.faulty[sw_idx] = 1'b0;
            nxt_st.oe_cnt[sw_idx] = '0;
          end
        end
      end else if (miss == 2'b00) begin
        nxt_st.oe_cnt[sw_idx] = '0;
      end else begin
        if (st_ff.oe_cnt[sw_idx] != '0 && st_ff.oe_hi[sw_idx] == miss[1])
        begin
          nxt_st.oe_cnt[sw_idx] = st_ff.oe_cnt[sw_idx] + 1'b1;
        end else begin
          nxt_st.oe_cnt[sw_idx] = 4'h1;
        end
        nxt_st.oe_hi[sw_idx] = miss[1];
        if (nxt_st.oe_cnt[sw_idx] >= oe_dly) begin
          nxt_st.faulty[sw_idx] = 1'b1;
          nxt_st.disabled[sw_idx] = act_en[ALM_OE];
        end
      end
    end
    nxt_st.alarm = {|st_ff.faulty, |st_ff.wear_flag, st_ff.fast_act[3],
                    |st_ff.fast_act[2:0], st_ff.dly_act};
    for (int s = 0; s < NS; s++) begin
      nxt_st.contact[s] = sec_alarm_out[s]
        ? (any_ind ? sec_alarm_pol[s] : !sec_alarm_pol[s])
        : (ctl_on[s] && !st_ff.force_off[s]
           && (!st_ff.disabled[s] || st_ff.retry_on));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign alarm_active = st_ff.alarm & (ind_en | act_ok);
  assign contact = st_ff.contact;
  assign sec_faulty = st_ff.faulty;
  assign sec_disabled = st_ff.disabled;
  assign standby_req = st_ff.standby;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_std_rise_cause: assert property (@(posedge clk) disable iff (rst)
    $rose(st_ff.dly_act[ALM_UV]) |-> $past(cond[ALM_UV]) && $past(s_tick))
    else $error("undervoltage rose without held condition");
  a_timer_restart: assert property (@(posedge clk) disable iff (rst)
    (cond[ALM_OV] == st_ff.dly_act[ALM_OV]) |=> st_ff.dly_cnt[ALM_OV] == '0)
    else $error("delay timer not restarted");
  a_act_shows_ind: assert property (@(posedge clk) disable iff (rst)
    st_ff.alarm[ALM_UC] && act_en[ALM_UC] |-> alarm_active[ALM_UC])
    else $error("actuated alarm not indicated");
  a_no_act_ind_only: assert property (@(posedge clk) disable iff (rst)
    !act_alm[ALM_OC] && !act_alm[ALM_OVC] && !act_alm[ALM_UNC])
    else $error("indication-only alarm actuates");
  a_fixed_kept: assert property (@(posedge clk) disable iff (rst)
    !full_act && fast_mask == '0 |=> (st_ff.force_off & sec_fixed) == '0)
    else $error("fixed section dropped by partial actuation");
  a_suppress_act: assert property (@(posedge clk) disable iff (rst)
    suppress |-> !act_alm[ALM_UC] && !act_alm[ALM_P])
    else $error("actuation not suppressed");
  a_one_step: assert property (@(posedge clk) disable iff (rst)
    fast_mask == '0 |=>
    $countones(st_ff.force_off & ~$past(st_ff.force_off)) <= 1)
    else $error("more than one section dropped");
  a_fast_together: assert property (@(posedge clk) disable iff (rst)
    (fast_mask != '0) ##1 $stable(fast_mask) |->
    (fast_mask & ~st_ff.force_off) == '0)
    else $error("fast drop not simultaneous");
  a_fast_release: assert property (@(posedge clk) disable iff (rst)
    $fell(st_ff.fast_act[3]) |->
    $past(st_ff.fast_cnt[3]) == 13'(FAST_OFF_MS))
    else $error("fast release before hold time");
  a_nc_immediate: assert property (@(posedge clk) disable iff (rst)
    ctl_running |=> !st_ff.dly_act[ALM_NC])
    else $error("not-controlling alarm not cleared");
  c_fast_drop: cover property (@(posedge clk) disable iff (rst)
    $rose(st_ff.fast_act[0]));
  c_std_act: cover property (@(posedge clk) disable iff (rst)
    $rose(st_ff.standby));
  c_faulty: cover property (@(posedge clk) disable iff (rst)
    $rose(|st_ff.disabled));
endmodule

/* File: dv/pas_plant_model.sv */
// Contactors and controller state machine facing the supervisor
`timescale 1ns/1ps
module pas_plant_model #(
  parameter int NS = 18
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [NS-1:0] contact,
  input wire logic standby_req,
  input wire logic run_req,
  output logic ctl_running,
  output logic [NS-1:0] closed_ff
);
  // Control stops whenever the supervisor forces standby
  assign ctl_running = run_req & ~standby_req;
  // Contactors follow their drive one cycle late
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      closed_ff <= '0;
    end else begin
      closed_ff <= contact;
    end
  end
endmodule

/* File: dv/pas_supervisor_tb.sv */
// Self-checking testbench of the alarm supervisor
`timescale 1ns/1ps
module pas_supervisor_tb import pas_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [N_STD_IN-1:0] std_cond = '0;
  logic [2:0][15:0] u_ln = {3{16'h0064}};
  logic [15:0] u_nom = 16'h0064;
  logic [15:0] ctl_bw = '0;
  logic signed [15:0] p_fh = '0, p_lim = '0, dq_ctl = '0;
  logic signed [15:0] internal_temperature = '0, external_temperature = '0;
  logic p_signed = 1'b0, p_above = 1'b0, ext_in = 1'b0, run_req = 1'b0;
  logic output_recognition = 1'b0, aor_start = 1'b0, ct_test = 1'b0;
  logic auto_connection_detection = 1'b0, sw_evt = 1'b0, ctl_running;
  logic [1:0] t_src_ext = '0, t_above = '0;
  logic [1:0][15:0] t_lim = '0;
  logic [N_ALL-1:0] ind_en = '0, act_en = '0, alarm_active;
  logic [N_DLY-1:0][10:0] dly_s = '0;
  logic [13:0] wear_lim_k = '0;
  logic [6:0] oe_pct = 7'h14;
  logic [3:0] oe_dly = 4'h3;
  logic [17:0] sec_fixed = '0, sec_edit = '0, sec_alarm_out = '0;
  logic [17:0] sec_alarm_pol = '0, ctl_on = '0, cnt_clr = '0;
  logic [17:0] contact, sec_faulty, sec_disabled;
  logic [17:0][2:0] sec_ph = '0;
  logic [4:0] sw_idx = '0;
  logic [2:0][15:0] sw_q = {3{16'h03e8}}, sw_dq = '0;
  logic standby_req, ov_seen = 1'b0;
  int failures = 0, n_compared = 0, n;
  int mc[18], mp[18];
  logic [17:0] mf = '0, md = '0, ph_m;
  int es[12] = '{5, 5, 5, 5, 5, 5, 6, 6, 6, 7, 7, 7};
  int ed[12] = '{700, 700, 900, 700, 700, 700, 1500, 1500, 1500, 1500,
    1500, 1500};

  always #25 clk = ~clk;

  // Small ms count and retry period keep the run inside its budget
  pas_supervisor #(.NS(18), .W(16), .MS_CYCLES(10), .RETRY_SEC(3))
    dut (.clk, .rst,
    .std_cond, .u_ln, .u_nom, .p_fh, .p_lim, .p_signed, .p_above, .dq_ctl,
    .ctl_bw, .internal_temperature, .external_temperature, .t_src_ext,
    .t_above, .t_lim, .ext_in, .ctl_running, .output_recognition,
    .aor_start, .auto_connection_detection, .ct_test, .ind_en, .act_en,
    .dly_s, .wear_lim_k, .oe_pct, .oe_dly, .sec_fixed, .sec_ph, .sec_edit,
    .sec_alarm_out, .sec_alarm_pol, .ctl_on, .cnt_clr, .sw_evt, .sw_idx,
    .sw_q, .sw_dq, .alarm_active, .contact, .sec_faulty, .sec_disabled,
    .standby_req);

  pas_plant_model #(.NS(18)) plant (.clk, .rst, .contact, .standby_req,
    .run_req, .ctl_running, .closed_ff());

  always @(negedge clk) begin
    if (alarm_active[ALM_OV] === 1'b1) begin
      ov_seen = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask

  task automatic close_out();
    if (failures == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // Counts settled cycles until an alarm bit takes the wanted level
  task automatic wait_for(input int i, input logic v, input int lim);
    n = 0;
    while (alarm_active[i] !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  // One switching of a section, mirrored in the reference counters
  task automatic sw(input int s, input int d);
    int tol;
    int p;
    cyc(1);
    sw_evt <= 1'b1;
    sw_idx <= 5'(s);
    sw_dq <= {3{16'(d)}};
    cyc(1);
    sw_evt <= 1'b0;
    tol = 1000 * oe_pct / 100;
    p = (d + tol < 1000) ? -1 : (d > 1000 + tol) ? 1 : 0;
    if (p == 0) mc[s] = 0;
    else if (p == mp[s]) mc[s]++;
    else mc[s] = 1;
    mp[s] = p;
    if (mc[s] >= oe_dly) begin
      mf[s] = 1'b1;
      md[s] = act_en[ALM_OE];
    end
    cyc(40);
    @(negedge clk);
    chk(sec_faulty, mf);
    chk(sec_disabled, md);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(71944));
    cyc(1);
    ctl_on <= 18'($urandom);
    sec_fixed <= 18'($urandom);
    sec_alarm_pol <= 18'($urandom);
    sec_ph <= 54'({$urandom, $urandom});
    t_src_ext <= 2'($urandom);
    cyc(9);
    @(negedge clk);
    chk(alarm_active, 0);
    chk(contact, 0);
    chk(sec_disabled, 0);
    cyc(1);
    rst <= 1'b0;
    ind_en <= (19'h1 << ALM_UV) | (19'h1 << ALM_OV) | (19'h1 << ALM_NC)
      | (19'h1 << ALM_RF) | (19'h1 << ALM_OE) | (19'h1 << ALM_WEAR);
    dly_s[ALM_UV] <= 11'h002;
    dly_s[ALM_OV] <= 11'h003;
    std_cond[ALM_UV] <= 1'b1;
    // Short bursts never reach the 3 s delay
    fork
      repeat (3) begin
        cyc(1);
        std_cond[ALM_OV] <= 1'b1;
        cyc(12000);
        std_cond[ALM_OV] <= 1'b0;
        cyc(6000);
      end
    join_none
    wait_for(ALM_UV, 1'b1, 32000);
    chk(32'(n inside {[20000:30010]}), 1);
    chk(alarm_active[ALM_NC], 1);
    chk(contact, ctl_on);
    cyc(1);
    run_req <= 1'b1;
    cyc(3);
    @(negedge clk);
    chk(alarm_active[ALM_NC], 0);
    cyc(1);
    ind_en[ALM_EXT] <= 1'b1;
    act_en[ALM_EXT] <= 1'b1;
    cyc(2);
    ext_in <= 1'b1;
    wait_for(ALM_EXT, 1'b1, 300);
    chk(32'(n inside {[180:210]}), 1);
    cyc(2);
    @(negedge clk);
    chk(contact, 0);
    chk(standby_req, 1);
    cyc(1);
    ext_in <= 1'b0;
    wait_for(ALM_EXT, 1'b0, 52000);
    chk(32'(n inside {[50000:51000]}), 1);
    cyc(3);
    @(negedge clk);
    chk(contact, ctl_on);
    for (int i = 0; i < 12; i++) begin
      if (i == 6) begin
        chk(contact, ctl_on);
        cyc(1);
        act_en[ALM_OE] <= 1'b1;
        cyc(2);
      end
      sw(es[i], ed[i]);
    end
    chk(alarm_active[ALM_OE], 1);
    // Retry window is open: disabled sections still follow the controller
    chk(contact, ctl_on);
    md[6] = 1'b0;
    mf[6] = 1'b0;
    sw(6, 1000);
    chk(contact, ctl_on & ~md);
    cyc(1);
    sec_edit[7] <= 1'b1;
    cyc(1);
    sec_edit[7] <= 1'b0;
    md[7] = 1'b0;
    mf[7] = 1'b0;
    cyc(3);
    @(negedge clk);
    chk(sec_disabled, md);
    chk(sec_faulty, mf);
    chk(alarm_active[ALM_WEAR], 1);
    cyc(1);
    cnt_clr[5] <= 1'b1;
    cyc(1);
    cnt_clr[5] <= 1'b0;
    cyc(40);
    @(negedge clk);
    chk(alarm_active[ALM_WEAR], 1);
    cyc(1);
    cnt_clr <= 18'h000c0;
    cyc(1);
    cnt_clr <= '0;
    cyc(40);
    @(negedge clk);
    chk(alarm_active[ALM_WEAR], 0);
    chk(alarm_active[ALM_RF], 0);
    chk(ov_seen, 0);
    // Phase 1 just under the fixed threshold, phase 0 right at it
    cyc(1);
    act_en[ALM_VL] <= 1'b1;
    u_ln[1] <= 16'h0013;
    u_ln[0] <= 16'h0014;
    wait_for(ALM_VL, 1'b1, 300);
    chk(32'(n inside {[180:210]}), 1);
    cyc(2);
    @(negedge clk);
    for (int s = 0; s < 18; s++) begin
      ph_m[s] = sec_ph[s][1];
    end
    chk(contact, ctl_on & ~ph_m);
    chk(standby_req, 1);
    cyc(1);
    sec_alarm_out <= '1;
    cyc(2);
    @(negedge clk);
    chk(contact, sec_alarm_pol);
    cyc(1);
    ind_en <= '0;
    act_en <= '0;
    cyc(2);
    @(negedge clk);
    chk(contact ^ sec_alarm_pol, 18'h3ffff);
    close_out();
  end

  // Run needs about 72000 cycles
  initial begin
    cyc(90000);
    failures++;
    close_out();
  end
endmodule
